// [rtl/drive_test_option_sequencer.sv]
/*
 * maintenance test sequencer: panel parameter entry, option decode
 * and control of seek and read/write exercise runs.
 * assumes raw panel pins (synchronised here) and a one-cycle done
 * pulse from the drive machinery for every access.
 */


module drive_test_option_sequencer
    import test_seq_pkg::*;
#(
    parameter int          HEAD_COUNT   = 16,     // heads per cylinder
    parameter int          RECORD_COUNT = 64,     // records per track
    parameter int          PASS_LENGTH  = 842,    // seeks in one sequential pass
    parameter int          STOP_SEEKS   = STOP_SEEK_COUNT, // end-of-test seek count
    parameter logic [15:0] MAINT_CYL    = 16'd842 // reserved maintenance cylinder
) (
    input  wire logic          clock_i,         // 10 MHz clock
    input  wire logic          sys_rst_i,       // async reset, active high
    input  wire logic          go_switch_i,     // go switch, raw pin
    input  wire logic          clear_switch_i,  // clear switch, raw pin
    input  wire logic          digit_strobe_i,  // entry strobe, raw pin
    input  wire logic [7:0]    digit_pair_i,    // two digits, raw pins
    input  wire logic          load_test_i,     // test loaded pulse
    input  wire seek_pattern_t pattern_i,       // loaded seek pattern
    input  wire test_class_t   class_i,         // loaded entry class
    input  wire logic          access_done_i,   // access finished
    input  wire logic          read_error_i,    // read error with done
    input  wire logic          other_error_i,   // other error with done
    input  wire logic          severe_error_i,  // most severe class
    input  wire logic [3:0]    param_sel_i,     // shown parameter index
    output logic               access_req_o,    // request one access
    output access_req_t        access_o,        // access target
    output logic               running_o,       // test executing
    output logic               stopped_o,       // end-of-test or error stop
    output logic               entry_refused_o, // entry on refusing test
    output logic               sel_error_o,     // selector outside 80..8F
    output logic [15:0]        param_value_o,   // shown parameter value
    output logic [15:0]        read_err_count_o,// read error counter
    output logic [4:0]         log_count_o,     // error log entries used
    output logic               log_full_o       // seventeenth error seen
);

    // ********************
    // pin synchronisers
    // ********************

    logic [1:0] go_sync_reg, clr_sync_reg, stb_sync_reg;
    logic       go_prev_reg, clr_prev_reg, stb_prev_reg;

    logic [7:0] digit_meta_reg;
    logic [7:0] digit_reg;

    // two flops per panel pin; only the second stage is looked at
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            go_sync_reg  <= 2'b00;
            clr_sync_reg <= 2'b00;
            stb_sync_reg <= 2'b00;
            go_prev_reg  <= 1'b0;
            clr_prev_reg <= 1'b0;
            stb_prev_reg <= 1'b0;
        end else begin
            go_sync_reg  <= {go_sync_reg[0], go_switch_i};
            clr_sync_reg <= {clr_sync_reg[0], clear_switch_i};
            stb_sync_reg <= {stb_sync_reg[0], digit_strobe_i};
            go_prev_reg  <= go_sync_reg[1];
            clr_prev_reg <= clr_sync_reg[1];
            stb_prev_reg <= stb_sync_reg[1];
        end
    end

    // digit pins take two flops like the strobes; the panel holds
    // them long enough that both stages settle before the press
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            digit_meta_reg <= 8'h00;
            digit_reg      <= 8'h00;
        end else begin
            digit_meta_reg <= digit_pair_i;
            digit_reg      <= digit_meta_reg;
        end
    end

    logic go_press, clr_press, stb_press;
    assign go_press  = go_sync_reg[1] & ~go_prev_reg;
    assign clr_press = clr_sync_reg[1] & ~clr_prev_reg;
    assign stb_press = stb_sync_reg[1] & ~stb_prev_reg;

    // ********************
    // parameter entry: selector then two halves
    // ********************

    typedef enum logic [2:0] {
        EN_SEL  = 3'b001,
        EN_HIGH = 3'b010,
        EN_LOW  = 3'b100
    } entry_state_t;

    entry_state_t entry_reg;
    logic [3:0]   sel_reg;
    logic [7:0]   high_half_reg;
    logic [15:0]  param_reg [PARAM_COUNT];
    logic         sel_error_reg, refused_reg;
    logic         entry_ok;

    assign entry_ok = (class_i != CLASS_REFUSES);

    // selector, then high pair, then low pair completes a value
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            entry_reg     <= EN_SEL;
            sel_reg       <= 4'h0;
            high_half_reg <= 8'h00;
            sel_error_reg <= 1'b0;
            refused_reg   <= 1'b0;
        end else if (clr_press) begin
            entry_reg     <= EN_SEL;
            sel_error_reg <= 1'b0;
            refused_reg   <= 1'b0;
        end else if (stb_press) begin
            case (entry_reg)
                EN_SEL: begin
                    // only 80..8F names a parameter
                    if (digit_reg >= PARAM_SEL_LO && digit_reg <= PARAM_SEL_HI) begin
                        sel_reg       <= digit_reg[3:0];
                        sel_error_reg <= 1'b0;
                        refused_reg   <= !entry_ok;
                        entry_reg     <= entry_ok ? EN_HIGH : EN_SEL;
                    end else begin
                        sel_error_reg <= 1'b1;
                    end
                end
                EN_HIGH: begin
                    high_half_reg <= digit_reg;
                    entry_reg     <= EN_LOW;
                end
                EN_LOW:  entry_reg <= EN_SEL;
                default: entry_reg <= EN_SEL;
            endcase
        end
    end

    // parameter store: every value kept raw; radix is the user's view
    genvar gp;
    generate
        for (gp = 0; gp < PARAM_COUNT; gp++) begin : g_param
            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    param_reg[gp] <= PARAM_RESET;
                end else if (clr_press) begin
                    param_reg[gp] <= PARAM_RESET;
                end else if (stb_press && entry_reg == EN_LOW && sel_reg == 4'(gp)) begin
                    param_reg[gp] <= {high_half_reg, digit_reg};
                end
            end
        end
    endgenerate

    // ********************
    // option decode from the option word
    // ********************

    logic [15:0] opt;
    logic        stop_at_end_option, single_opt, rd_ovr_opt;
    logic        rand_head_opt, rand_rec_opt, man_head_opt, man_rec_opt, count_err_opt;

    // low byte tester bits, high byte diagnostic bits, all binary; bit 2 unread
    assign opt                = param_reg[TEST_OPTION_WORD[3:0]];
    assign stop_at_end_option = opt[OPT_STOP_AT_END];
    assign single_opt         = opt[OPT_SINGLE];
    assign rd_ovr_opt         = opt[OPT_READ_ERR_OVR];
    assign rand_head_opt      = opt[OPT_RANDOM_HEAD];
    assign rand_rec_opt       = opt[OPT_RANDOM_REC];
    assign man_head_opt       = opt[OPT_MANUAL_HEAD];
    assign man_rec_opt        = opt[OPT_MANUAL_REC];
    assign count_err_opt      = opt[OPT_COUNT_ERRORS];

    // ********************
    // run sequencer
    // ********************

    seq_state_t  state_reg;
    logic [31:0] seek_cnt_reg;
    logic [31:0] limit;
    logic        loaded_reg;
    logic        end_hit;

    // end count per pattern; single seeks and read/write have no
    // defined end, so they run until go as with the option clear
    always_comb begin
        case (pattern_i)
            PAT_DIRECT_CONT, PAT_RANDOM: limit = 32'(STOP_SEEKS);
            PAT_SEQ_FWD, PAT_SEQ_REV:   limit = 32'(PASS_LENGTH);
            PAT_SEQ_ALT:                limit = 32'(2 * PASS_LENGTH);
            PAT_PAIRWISE:               limit = 32'(PASS_LENGTH * PASS_LENGTH);
            default:                    limit = 32'h0000_0000;
        endcase
    end

    assign end_hit = stop_at_end_option && (limit != 32'h0000_0000)
                     && access_done_i && (seek_cnt_reg + 32'd1 >= limit);

    logic err_stop;
    assign err_stop = access_done_i && ((read_error_i && !rd_ovr_opt) || other_error_i);

    // one-hot run control
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg    <= ST_IDLE;
            seek_cnt_reg <= 32'h0000_0000;
            loaded_reg   <= 1'b0;
        end else begin
            if (load_test_i) loaded_reg <= 1'b1;
            case (state_reg)
                ST_IDLE: begin
                    seek_cnt_reg <= 32'h0000_0000;
                    if (go_press && loaded_reg)
                        state_reg <= single_opt ? ST_STEP : ST_RUN;
                end
                ST_RUN, ST_WAIT: begin
                    if (access_done_i) seek_cnt_reg <= seek_cnt_reg + 32'd1;
                    if (end_hit || err_stop) state_reg <= ST_STOP;
                    else if (go_press) state_reg <= ST_IDLE;
                    else if (state_reg == ST_RUN) state_reg <= ST_WAIT;
                    else if (access_done_i) state_reg <= single_opt ? ST_IDLE : ST_RUN;
                end
                ST_STEP: state_reg <= ST_WAIT;
                ST_STOP: begin
                    // stays stopped; clear then reload then go restarts
                    if (clr_press) begin
                        state_reg  <= ST_IDLE;
                        loaded_reg <= 1'b0;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ********************
    // head and record selection
    // ********************

    logic [15:0] lfsr_reg;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) lfsr_reg <= LFSR_SEED;
        else lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end

    logic [7:0] head_next, rec_next;
    always_comb begin
        head_next = 8'h00;
        rec_next  = 8'h00;
        if (man_head_opt) head_next = param_reg[HEAD_PARAM[3:0]][7:0];
        else if (rand_head_opt) head_next = 8'(lfsr_reg[7:0] % HEAD_COUNT);
        if (man_rec_opt) rec_next = param_reg[RECORD_PARAM[3:0]][7:0];
        else if (rand_rec_opt) rec_next = 8'(lfsr_reg[15:8] % RECORD_COUNT);
    end

    // request on each launch; the cylinder is fixed so
    // customer data is never touched
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            access_o     <= '0;
            access_req_o <= 1'b0;
        end else begin
            access_req_o <= (state_reg == ST_RUN) || (state_reg == ST_STEP);
            if (state_reg == ST_RUN || state_reg == ST_STEP) begin
                access_o.cylinder   <= MAINT_CYL;
                access_o.head       <= head_next;
                access_o.record_num <= rec_next;
            end
        end
    end

    // ********************
    // read error counter and error log
    // ********************

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) read_err_count_o <= 16'h0000;
        else if (clr_press) read_err_count_o <= 16'h0000;
        else if (access_done_i && read_error_i && rd_ovr_opt)
            read_err_count_o <= read_err_count_o + 16'd1;
    end

    logic log_event;
    assign log_event = access_done_i && (read_error_i || other_error_i)
                       && (count_err_opt || severe_error_i);

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            log_count_o <= 5'd0;
            log_full_o  <= 1'b0;
        end else if (clr_press) begin
            log_count_o <= 5'd0;
            log_full_o  <= 1'b0;
        end else if (log_event) begin
            if (log_count_o == 5'(LOG_DEPTH)) log_full_o <= 1'b1;
            else log_count_o <= log_count_o + 5'd1;
        end
    end

    // ********************
    // status outputs
    // ********************

    assign running_o       = (state_reg == ST_RUN) || (state_reg == ST_WAIT)
                             || (state_reg == ST_STEP);
    assign stopped_o       = (state_reg == ST_STOP);
    assign entry_refused_o = refused_reg;
    assign sel_error_o     = sel_error_reg;
    assign param_value_o   = param_reg[param_sel_i];

endmodule

// [rtl/test_seq_pkg.sv]
/*
 * constants, enums and carriers of the maintenance test sequencer.
 * assumes one 10 MHz clock domain.
 */
package test_seq_pkg;

    // ********************
    // parameter selector range and numbers
    // ********************
    localparam logic [7:0]  PARAM_SEL_LO      = 8'h80;
    localparam logic [7:0]  PARAM_SEL_HI      = 8'h8F;
    localparam logic [7:0]  TEST_OPTION_WORD  = 8'h80;
    localparam logic [7:0]  RECORD_PARAM      = 8'h83;
    localparam logic [7:0]  HEAD_PARAM        = 8'h85;
    localparam int          PARAM_COUNT       = 16;
    localparam logic [15:0] PARAM_RESET       = 16'h0000;
    localparam logic [15:0] READ_ERR_STATUS   = 16'h0094;

    // ********************
    // field tester option bits (low byte) and diagnostic bits (high byte)
    // ********************
    localparam int OPT_STOP_AT_END  = 0;
    localparam int OPT_SINGLE       = 1;
    localparam int OPT_UNUSED       = 2;
    localparam int OPT_READ_ERR_OVR = 3;
    localparam int OPT_RANDOM_HEAD  = 4;
    localparam int OPT_RANDOM_REC   = 5;
    localparam int OPT_MANUAL_HEAD  = 6;
    localparam int OPT_MANUAL_REC   = 7;
    localparam int OPT_COUNT_ERRORS = 10;

    // ********************
    // timing and sizes
    // ********************
    localparam int          STOP_SEEK_COUNT = 10000;
    localparam int          LOG_DEPTH       = 16;
    localparam logic [15:0] LFSR_SEED       = 16'hACE1;

    // ********************
    // enumerations
    // ********************
    typedef enum logic [2:0] {
        PAT_DIRECT      = 3'h0,
        PAT_DIRECT_CONT = 3'h1,
        PAT_RANDOM      = 3'h2,
        PAT_SEQ_FWD     = 3'h3,
        PAT_SEQ_REV     = 3'h4,
        PAT_SEQ_ALT     = 3'h5,
        PAT_PAIRWISE    = 3'h6,
        PAT_READ_WRITE  = 3'h7
    } seek_pattern_t;

    typedef enum logic [1:0] {
        CLASS_REQUIRES = 2'h0,
        CLASS_DEFAULTS = 2'h1,
        CLASS_REFUSES  = 2'h2
    } test_class_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_RUN   = 5'b00010,
        ST_WAIT  = 5'b00100,
        ST_STEP  = 5'b01000,
        ST_STOP  = 5'b10000
    } seq_state_t;

    // one access toward the drive machinery
    typedef struct packed {
        logic [15:0] cylinder;
        logic [7:0]  head;
        logic [7:0]  record_num;
    } access_req_t;

endpackage

// [test/drive_model.sv]
/* behavioural drive machinery for the sequencer bench.
   assumes one clock; answers each request after a delay. */
module drive_model (
    input  wire logic clock_i,   // system clock
    input  wire logic sys_rst_i, // async reset
    input  wire logic req_i,     // access request pulse
    input  wire logic err_i,     // bench asks for read errors
    input  wire logic slow_i,    // bench asks for slow answers
    output logic      done_o,    // access finished pulse
    output logic      rd_err_o,  // read error qualifier
    output logic      oth_err_o, // other error qualifier
    output logic      severe_o,  // severe class qualifier
    output int        count_o    // accesses seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // answer timing
    // ********************
    int   wait_cnt;
    logic busy;
    logic tog;
    // one access in flight, counted when asked
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wait_cnt <= 0;
            busy     <= 1'b0;
            tog      <= 1'b0;
            done_o   <= 1'b0;
            count_o  <= 0;
        end else begin
            tog    <= !tog;
            done_o <= 1'b0;
            if (req_i) begin
                busy     <= 1'b1;
                wait_cnt <= slow_i ? 6 : 1;
                count_o  <= count_o + 1;
            end else if (busy && wait_cnt == 0) begin
                busy   <= 1'b0;
                done_o <= 1'b1;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
    // qualifiers only mean something with done, so they wander otherwise
    assign rd_err_o  = done_o ? err_i : tog;
    assign oth_err_o = done_o ? 1'b0 : !tog;
    assign severe_o  = done_o ? 1'b0 : tog;
endmodule

// [test/seq_assertions.sv]
/* port checker for the maintenance test sequencer.
   assumes it is bound onto the sequencer and shares its parameters. */
module seq_assertions
    import test_seq_pkg::*;
#(
    parameter int          HEAD_COUNT   = 16,
    parameter int          RECORD_COUNT = 64,
    parameter logic [15:0] MAINT_CYL    = 16'h034A
) (
    input wire logic        clock_i,          // system clock
    input wire logic        sys_rst_i,        // async reset
    input wire logic        access_req_o,     // access pulse
    input wire access_req_t access_o,         // access target
    input wire logic        running_o,        // test running
    input wire logic        stopped_o,        // test stopped
    input wire logic        access_done_i,    // access finished
    input wire logic        read_error_i,     // read error qualifier
    input wire logic [15:0] read_err_count_o, // read error counter
    input wire logic [4:0]  log_count_o,      // log entries used
    input wire logic        log_full_o        // log full flag
);
    // ********************
    // port relations
    // ********************
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_req_pulse: assert property (access_req_o |=> !access_req_o)
        else $error("access request longer than one cycle");
    a_cyl_maint: assert property (access_req_o |-> access_o.cylinder == MAINT_CYL)
        else $error("access outside maintenance cylinder");
    a_head_range: assert property (access_req_o |-> access_o.head < HEAD_COUNT)
        else $error("head number out of range");
    a_rec_range: assert property (access_req_o |-> access_o.record_num < RECORD_COUNT)
        else $error("record number out of range");
    a_stop_quiet: assert property (stopped_o |-> !access_req_o && !running_o)
        else $error("activity while stopped");
    a_log_bound: assert property (log_count_o <= 5'h10)
        else $error("error log beyond its depth");
    a_full_at_depth: assert property ($rose(log_full_o) |-> log_count_o == 5'h10)
        else $error("log full before the log was filled");
    // a counter step needs a finished read error
    a_rdcnt_cause: assert property (read_err_count_o != $past(read_err_count_o)
        && read_err_count_o != 16'h0000 |-> read_err_count_o == $past(read_err_count_o)
        + 16'h0001 && $past(access_done_i && read_error_i))
        else $error("read error counter moved without cause");
endmodule

bind drive_test_option_sequencer seq_assertions #(
    .HEAD_COUNT(HEAD_COUNT), .RECORD_COUNT(RECORD_COUNT), .MAINT_CYL(MAINT_CYL)
) u_chk (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .access_req_o(access_req_o),
    .access_o(access_o), .running_o(running_o), .stopped_o(stopped_o),
    .access_done_i(access_done_i), .read_error_i(read_error_i),
    .read_err_count_o(read_err_count_o), .log_count_o(log_count_o), .log_full_o(log_full_o)
);

// [test/test_drive_test_option_sequencer.sv]
/* self-checking bench for the maintenance test sequencer.
   assumes the drive model answers every access. */
module test_drive_test_option_sequencer;
    import test_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // signals and model state
    // ********************
    localparam int STOPS = 5;
    localparam int PASSL = 4;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, go_switch_i = 1'b0, clear_switch_i = 1'b0;
    logic digit_strobe_i = 1'b0, load_test_i = 1'b0, err_mode = 1'b0, slow = 1'b0;
    logic [7:0] digit_pair_i = 8'h00;
    logic [3:0] param_sel_i = 4'h0;
    seek_pattern_t pattern_i = PAT_DIRECT;
    test_class_t class_i = CLASS_REQUIRES;
    logic access_done_i, read_error_i, other_error_i, severe_error_i, access_req_o;
    logic running_o, stopped_o, entry_refused_o, sel_error_o, log_full_o;
    access_req_t access_o;
    logic [15:0] param_value_o, read_err_count_o, h, r;
    logic [4:0] log_count_o;
    int req_count, base, err_count = 0, total_checks = 0, cycles = 0;
    int exp_param [16];
    seek_pattern_t pats [6] = '{PAT_DIRECT_CONT, PAT_RANDOM, PAT_SEQ_FWD, PAT_SEQ_REV,
                                PAT_SEQ_ALT, PAT_PAIRWISE};
    int cnts [6] = '{STOPS, STOPS, PASSL, PASSL, 2 * PASSL, PASSL * PASSL};

    always #50 clock_i = !clock_i;

    drive_test_option_sequencer #(.PASS_LENGTH(PASSL), .STOP_SEEKS(STOPS)) DUT (
        .clock_i, .sys_rst_i, .go_switch_i, .clear_switch_i, .digit_strobe_i, .digit_pair_i,
        .load_test_i, .pattern_i, .class_i, .access_done_i, .read_error_i, .other_error_i,
        .severe_error_i, .param_sel_i, .access_req_o, .access_o, .running_o, .stopped_o,
        .entry_refused_o, .sel_error_o, .param_value_o, .read_err_count_o, .log_count_o,
        .log_full_o);
    drive_model u_drive (.clock_i, .sys_rst_i, .req_i(access_req_o), .err_i(err_mode),
        .slow_i(slow), .done_o(access_done_i), .rd_err_o(read_error_i),
        .oth_err_o(other_error_i), .severe_o(severe_error_i), .count_o(req_count));

    // ********************
    // shared tasks
    // ********************
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // a hang ends in the same report
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // raw pins: data first, press held past the sync
    task automatic press(input logic [7:0] v, input int which);
        @(posedge clock_i) digit_pair_i <= v;
        repeat (4) @(posedge clock_i);
        if (which == 0) digit_strobe_i <= 1'b1;
        else if (which == 1) go_switch_i <= 1'b1;
        else clear_switch_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        digit_strobe_i <= 1'b0;
        go_switch_i <= 1'b0;
        clear_switch_i <= 1'b0;
        repeat (6) @(posedge clock_i);
    endtask
    task automatic enter(input logic [7:0] s, input logic [15:0] v);
        press(s, 0);
        press(v[15:8], 0);
        press(v[7:0], 0);
        exp_param[s[3:0]] = v;
    endtask
    task automatic rd_all();
        for (int i = 0; i < 16; i++) begin
            @(posedge clock_i) param_sel_i <= 4'(i);
            @(negedge clock_i);
            chk(param_value_o, exp_param[i]);
        end
    endtask
    task automatic clr();
        press(8'h00, 2);
        exp_param = '{default: 0};
    endtask
    // option word, then load, then go
    task automatic start(input logic [15:0] opt, input seek_pattern_t p);
        enter(8'h80, opt);
        @(posedge clock_i) pattern_i <= p;
        load_test_i <= 1'b1;
        @(posedge clock_i) load_test_i <= 1'b0;
        press(8'h00, 1);
    endtask
    task automatic stop_run(input seek_pattern_t p, input int n);
        base = req_count;
        clr();
        start(16'h0001, p);
        for (int i = 0; i < 3000 && !stopped_o; i++) @(negedge clock_i);
        chk(stopped_o, 1'b1);
        chk(req_count - base, n);
        press(8'h00, 1);
        chk(req_count - base, n);
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        exp_param = '{default: 0};
        void'($urandom(32'h742f_7878));
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd_all();
        chk(read_err_count_o, 0);
        for (int i = 0; i < 6; i++) enter(8'h80 | 8'($urandom % 16), 16'($urandom));
        rd_all();
        press(8'h90, 0);
        chk(sel_error_o, 1'b1);
        press(8'h7F, 0);
        chk(sel_error_o, 1'b1);
        enter(8'h8F, 16'h1234);
        chk(sel_error_o, 1'b0);
        rd_all();
        clr();
        rd_all();
        $display("test entry done");
        for (int k = 0; k < 6; k++) begin
            slow <= 1'($urandom % 2);
            stop_run(pats[k], cnts[k]);
        end
        $display("test stop at end done");
        base = req_count;
        clr();
        start(16'h0004, PAT_SEQ_FWD);
        for (int i = 0; i < 3000 && req_count < base + 3 * PASSL; i++) @(negedge clock_i);
        chk(running_o, 1'b1);
        chk(stopped_o, 1'b0);
        press(8'h00, 1);
        base = req_count;
        repeat (40) @(negedge clock_i);
        chk(req_count, base);
        chk(running_o, 1'b0);
        base = req_count;
        clr();
        start(16'h0002, PAT_DIRECT_CONT);
        repeat (40) @(negedge clock_i);
        chk(req_count - base, 1);
        press(8'h00, 1);
        repeat (40) @(negedge clock_i);
        chk(req_count - base, 2);
        $display("test repeat and single done");
        slow <= 1'b1;
        err_mode <= 1'b1;
        clr();
        start(16'h0408, PAT_READ_WRITE);
        for (int i = 0; i < 3000 && read_err_count_o < 16; i++) @(negedge clock_i);
        @(negedge clock_i);
        chk(log_count_o, 16);
        chk(log_full_o, 1'b0);
        for (int i = 0; i < 3000 && read_err_count_o < 17; i++) @(negedge clock_i);
        @(negedge clock_i);
        chk(running_o, 1'b1);
        chk(log_full_o, 1'b1);
        press(8'h00, 1);
        base = req_count;
        clr();
        start(16'h0000, PAT_READ_WRITE);
        for (int i = 0; i < 3000 && !stopped_o; i++) @(negedge clock_i);
        chk(stopped_o, 1'b1);
        chk(req_count - base, 1);
        chk(read_err_count_o, 0);
        err_mode <= 1'b0;
        $display("test read errors done");
        h = 16'($urandom % 16);
        r = 16'($urandom % 64);
        clr();
        enter(8'h85, h);
        enter(8'h83, r);
        start(16'h00C0, PAT_READ_WRITE);
        for (int i = 0; i < 3000 && !access_req_o; i++) @(negedge clock_i);
        chk(access_o.head, h[7:0]);
        chk(access_o.record_num, r[7:0]);
        press(8'h00, 1);
        rd_all();
        base = req_count;
        clr();
        start(16'h0030, PAT_READ_WRITE);
        for (int i = 0; i < 3000 && req_count < base + 8; i++) @(negedge clock_i);
        chk(req_count - base, 8);
        press(8'h00, 1);
        clr();
        class_i <= CLASS_REFUSES;
        @(posedge clock_i) load_test_i <= 1'b1;
        @(posedge clock_i) load_test_i <= 1'b0;
        press(8'h80, 0);
        press(8'h12, 0);
        press(8'h34, 0);
        chk(entry_refused_o, 1'b1);
        rd_all();
        class_i <= CLASS_REQUIRES;
        $display("test heads records and classes done");
        summarize();
    end
endmodule
